//--- core/power_ctl_regs.vh
// What this block does
// - Regulator control bits 15:2 and power register bits 15:5 read fixed, ignore writes.
// - Power register bit 4: 0 pulls wake pin low, 1 releases it.
// - Power register bit 3: 0 makes wake pin input, 1 makes it output.
// - Wake pin input is active high; as output it is open-drain active low.
// - Power register bit 2 at 1 shuts regulators, analog reset and bandgap.
// - Bandgap power-down turns off analog, core and USB regulators, reset and bandgap.
// - After power-down only wake pin high as input, RTC alarm or a power register write re-enables the regulators.
// - Power register bit 1 shuts regulators and analog reset, bandgap stays on.
// - Power register bit 0 enables the RTC clock output pin.
// - Regulator control bit 1 selects core level: 0 is 1.3 V, 1 is 1.05 V.
// - Powered up: analog on, core on while strap low, USB on while enabled.
// - Power management register sits at address 1930h.
// - Core voltage select resets to the 1.3 V setting.
`ifndef POWER_CTL_REGS_VH
`define POWER_CTL_REGS_VH

// Byte addresses of the registers
`define RTC_PM_ADDR 16'h1930
`define REG_CTL_ADDR 16'h7004
`define PWR_STAT_ADDR 16'h7008

// Power management register fields
`define PM_WAKE_OUT 4
`define PM_WAKE_DIR 3
`define PM_BANDGAP_POWER_DOWN 2
`define PM_REG_PD 1
`define PM_CLKOUT_EN 0
`define PM_RESET 5'h10

// Regulator control register fields
`define RC_CORE_VSEL 1
`define RC_USB_EN 0
`define RC_RESET 2'h0

// Status register fields
`define ST_DOWN 0
`define ST_SETTLING 1
`define ST_STRAP 2
`define ST_WOKE_PIN 3
`define ST_WOKE_ALARM 4

// Bandgap recovery time and clock rate
`define BG_SETTLE_MS 100
`define CLK_MHZ 125
`define BG_SETTLE_CYCLES (`BG_SETTLE_MS * 1000 * `CLK_MHZ)

// AHB transfer type
`define HTRANS_NONSEQ 2'h2

`endif

//--- core/regulator_power_control.v
`include "power_ctl_regs.vh"

module regulator_power_control #(
	parameter ADDR_W = 16,
	parameter CNT_W = 24,
	parameter [CNT_W-1:0] SETTLE_CYCLES = `BG_SETTLE_CYCLES
) (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,

	// AHB-Lite slave
	input wire hsel,
	input wire [ADDR_W-1:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,

	// Wake pin, open drain
	input wire wake_pin_in,
	output reg wake_pin_out,
	output reg wake_pin_oe,

	// Wake sources and board strap
	input wire rtc_alarm,
	input wire core_regulator_strap,

	// Regulator and reference controls
	output reg analog_regulator_on,
	output reg core_regulator_on,
	output reg usb_regulator_on,
	output reg core_regulator_low_voltage,
	output reg bandgap_on,
	output reg analog_por_on,
	output reg rtc_clock_out_enable,
	output reg supply_settling
);

	// Stored register bits
	reg [4:0] pm_q;
	reg [4:0] pm_d;
	reg [1:0] rc_q;
	reg [1:0] rc_d;
	reg woke_pin_q;
	reg woke_pin_d;
	reg woke_alarm_q;
	reg woke_alarm_d;

	// Pending write of the data phase
	reg wr_pend_q;
	reg [ADDR_W-1:0] wr_addr_q;

	// Synchronisers for pins from other domains, one lane per pin
	wire [2:0] pin_raw;
	reg [2:0] pin_meta_q;
	reg [2:0] pin_sync_q;
	wire wake_sync_q;
	wire alarm_sync_q;
	wire strap_sync_q;
	genvar g;

	// Next values of the registered outputs
	reg power_down_d;
	reg wake_pin_oe_d;
	reg analog_regulator_on_d;
	reg core_regulator_on_d;
	reg usb_regulator_on_d;
	reg core_regulator_low_voltage_d;
	reg bandgap_on_d;
	reg analog_por_on_d;
	reg rtc_clock_out_enable_d;
	reg supply_settling_d;

	// Bandgap recovery timing
	reg [CNT_W-1:0] settle_cnt_q;
	reg [CNT_W-1:0] settle_cnt_d;
	reg bg_was_down_q;
	reg bg_was_down_d;

	// Decoded bus and power state
	wire addr_phase;
	wire rd_req;
	wire wr_req;
	wire wr_pm;
	wire wr_rc;
	wire wr_st;
	wire down;
	wire wake_by_pin;
	wire wake_by_alarm;
	wire wake_now;
	wire [31:0] rd_word;

	// Address phase is taken only while the bus is ready
	assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ);
	assign rd_req = addr_phase & ~hwrite;
	assign wr_req = addr_phase & hwrite;
	assign wr_pm = wr_pend_q & (wr_addr_q == `RTC_PM_ADDR);
	assign wr_rc = wr_pend_q & (wr_addr_q == `REG_CTL_ADDR);
	assign wr_st = wr_pend_q & (wr_addr_q == `PWR_STAT_ADDR);

	// Either power-down bit holds the regulators off
	assign down = pm_q[`PM_BANDGAP_POWER_DOWN] | pm_q[`PM_REG_PD];

	// Wake pin counts only as an input, active high
	assign wake_by_pin = wake_sync_q & ~pm_q[`PM_WAKE_DIR];
	assign wake_by_alarm = alarm_sync_q;
	assign wake_now = down & (wake_by_pin | wake_by_alarm);

	// Lane order: wake pin, alarm, strap
	assign pin_raw = {core_regulator_strap, rtc_alarm, wake_pin_in};
	assign wake_sync_q = pin_sync_q[0];
	assign alarm_sync_q = pin_sync_q[1];
	assign strap_sync_q = pin_sync_q[2];

	// Two-flop synchronisers; only the second stage is read
	// so a metastable first stage never reaches the decode
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_meta_q[g] <= 1'b0;
					pin_sync_q[g] <= 1'b0;
				end else begin
					pin_meta_q[g] <= pin_raw[g];
					pin_sync_q[g] <= pin_meta_q[g];
				end
			end
		end
	endgenerate

	// Next value of the power management register
	always @* begin
		pm_d = pm_q;
		if (wr_pm) begin
			pm_d = hwdata[4:0];
		end else if (wake_now) begin
			// Wake releases both power-down bits at once
			pm_d[`PM_BANDGAP_POWER_DOWN] = 1'b0;
			pm_d[`PM_REG_PD] = 1'b0;
		end
	end

	// Next value of the regulator control register
	always @* begin
		rc_d = rc_q;
		if (wr_rc) begin
			rc_d = hwdata[1:0];
		end
	end

	// Wake cause flags: a new wake beats a write-one clear
	always @* begin
		woke_pin_d = woke_pin_q;
		woke_alarm_d = woke_alarm_q;
		if (wr_st && hwdata[`ST_WOKE_PIN]) begin
			woke_pin_d = 1'b0;
		end
		if (wr_st && hwdata[`ST_WOKE_ALARM]) begin
			woke_alarm_d = 1'b0;
		end
		if (wake_now && !wr_pm && wake_by_pin) begin
			woke_pin_d = 1'b1;
		end
		if (wake_now && !wr_pm && wake_by_alarm) begin
			woke_alarm_d = 1'b1;
		end
	end

	// Bandgap recovery count starts when the bandgap comes back
	always @* begin
		settle_cnt_d = settle_cnt_q;
		bg_was_down_d = pm_q[`PM_BANDGAP_POWER_DOWN];
		if (pm_q[`PM_BANDGAP_POWER_DOWN]) begin
			settle_cnt_d = {CNT_W{1'b0}};
		end else if (bg_was_down_q) begin
			settle_cnt_d = SETTLE_CYCLES;
		end else if (settle_cnt_q != {CNT_W{1'b0}}) begin
			settle_cnt_d = settle_cnt_q - 1'b1;
		end
	end

	// Read word built from next values so a read right after a write sees it
	assign rd_word =
		(haddr == `RTC_PM_ADDR) ? {27'h0, pm_d} :
		(haddr == `REG_CTL_ADDR) ? {30'h0, rc_d} :
		(haddr == `PWR_STAT_ADDR) ? {27'h0, woke_alarm_d, woke_pin_d, strap_sync_q,
			(settle_cnt_d != {CNT_W{1'b0}}), (pm_d[`PM_BANDGAP_POWER_DOWN] | pm_d[`PM_REG_PD])} :
		32'h0;

	// Register state
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pm_q <= `PM_RESET;
			rc_q <= `RC_RESET;
			woke_pin_q <= 1'b0;
			woke_alarm_q <= 1'b0;
			settle_cnt_q <= {CNT_W{1'b0}};
			bg_was_down_q <= 1'b0;
		end else begin
			pm_q <= pm_d;
			rc_q <= rc_d;
			woke_pin_q <= woke_pin_d;
			woke_alarm_q <= woke_alarm_d;
			settle_cnt_q <= settle_cnt_d;
			bg_was_down_q <= bg_was_down_d;
		end
	end

	// Bus slave: zero wait states, always OKAY
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= {ADDR_W{1'b0}};
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
		end else begin
			wr_pend_q <= wr_req;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (wr_req) begin
				wr_addr_q <= haddr;
			end
			// Unmapped reads give zero; data held until next read
			if (rd_req) begin
				hrdata <= rd_word;
			end
		end
	end

	// Output next values from the next register state, so outputs
	// follow a write or a wake at the same edge that stores it
	always @* begin
		power_down_d = pm_d[`PM_BANDGAP_POWER_DOWN] | pm_d[`PM_REG_PD];
		// Pull low only as an output with the value bit cleared
		wake_pin_oe_d = pm_d[`PM_WAKE_DIR] & ~pm_d[`PM_WAKE_OUT];
		// Either bit removes all regulators and the analog reset
		analog_regulator_on_d = ~power_down_d;
		// Strap is static on the board; synced only to keep it glitch free
		core_regulator_on_d = ~power_down_d & ~strap_sync_q;
		usb_regulator_on_d = ~power_down_d & rc_d[`RC_USB_EN];
		analog_por_on_d = ~power_down_d;
		// Only the bandgap bit stops the reference
		bandgap_on_d = ~pm_d[`PM_BANDGAP_POWER_DOWN];
		core_regulator_low_voltage_d = rc_d[`RC_CORE_VSEL];
		rtc_clock_out_enable_d = pm_d[`PM_CLKOUT_EN];
		// High while the reference is off, low for one cycle as it returns, then high through its recovery count
		supply_settling_d = (settle_cnt_d != {CNT_W{1'b0}}) | pm_d[`PM_BANDGAP_POWER_DOWN];
	end

	// Pin and regulator outputs, all straight from flip-flops
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_pin_out <= 1'b0;
			wake_pin_oe <= 1'b0;
			analog_regulator_on <= 1'b1;
			core_regulator_on <= 1'b0;
			usb_regulator_on <= 1'b0;
			core_regulator_low_voltage <= 1'b0;
			bandgap_on <= 1'b1;
			analog_por_on <= 1'b1;
			rtc_clock_out_enable <= 1'b0;
			supply_settling <= 1'b0;
		end else begin
			// Open drain: only ever pulls low, enable set while pulling
			wake_pin_out <= 1'b0;
			wake_pin_oe <= wake_pin_oe_d;
			analog_regulator_on <= analog_regulator_on_d;
			core_regulator_on <= core_regulator_on_d;
			usb_regulator_on <= usb_regulator_on_d;
			analog_por_on <= analog_por_on_d;
			bandgap_on <= bandgap_on_d;
			core_regulator_low_voltage <= core_regulator_low_voltage_d;
			rtc_clock_out_enable <= rtc_clock_out_enable_d;
			supply_settling <= supply_settling_d;
		end
	end

endmodule

//--- bench/rpc_props.sv
module rpc_props (
	// Watched design ports
	input wire core_clk,
	input wire rst_n,
	input wire hsel,
	input wire hreadyout,
	input wire hresp,
	input wire wake_pin_in,
	input wire wake_pin_out,
	input wire rtc_alarm,
	input wire core_regulator_strap,
	input wire analog_regulator_on,
	input wire core_regulator_on,
	input wire usb_regulator_on,
	input wire bandgap_on,
	input wire analog_por_on,
	input wire supply_settling
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Power-down matrix
	pd_all_off_a: assert property (!bandgap_on |-> !analog_regulator_on && !core_regulator_on
		&& !usb_regulator_on && !analog_por_on) else $error("regulator on while bandgap down");
	por_track_a: assert property (analog_regulator_on == analog_por_on)
		else $error("analog reset not paired with analog regulator");
	usb_dep_a: assert property (usb_regulator_on |-> analog_regulator_on)
		else $error("usb regulator on during power-down");
	strap_off_a: assert property (core_regulator_strap && $past(core_regulator_strap, 4)
		|-> !core_regulator_on) else $error("core regulator on with strap high");
	// Open drain never drives high
	wake_out_a: assert property (!wake_pin_out) else $error("wake pin driven high");
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	// Wake timing, three edges through the synchroniser
	alarm_wake_a: assert property ($rose(rtc_alarm) && !analog_regulator_on
		|-> ##[1:4] analog_regulator_on) else $error("alarm did not wake regulators");
	stays_down_a: assert property (!analog_regulator_on && !hsel && !$past(rtc_alarm)
		&& !$past(wake_pin_in) |=> !analog_regulator_on) else $error("regulators woke with no cause");
	settle_a: assert property (!bandgap_on |-> supply_settling)
		else $error("not settling while bandgap down");
endmodule

bind regulator_power_control rpc_props i_rpc_props (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
	.hreadyout(hreadyout), .hresp(hresp), .wake_pin_in(wake_pin_in), .wake_pin_out(wake_pin_out),
	.rtc_alarm(rtc_alarm), .core_regulator_strap(core_regulator_strap), .analog_regulator_on(analog_regulator_on),
	.core_regulator_on(core_regulator_on), .usb_regulator_on(usb_regulator_on), .bandgap_on(bandgap_on),
	.analog_por_on(analog_por_on), .supply_settling(supply_settling));

//--- bench/wake_source.sv
module wake_source (
	// Pin control and outside driver
	input wire wake_pin_oe,
	input wire ext_high,
	output wire wake_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-down of the open drain wins over the outside source
	assign wake_pin_in = wake_pin_oe ? 1'b0 : ext_high;
endmodule

//--- bench/regulator_power_control_tb_top.sv
module regulator_power_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rtc_alarm = 0, core_regulator_strap = 0, ext = 0;
	logic [15:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [31:0] hwdata = 0, hrdata, rd;
	logic hreadyout, hresp, wake_pin_in, wake_pin_oe, ana_on, core_on, usb_on, low_v, bg_on, por_on;
	logic clk_out, settling;
	int n_fail = 0, checks_done = 0, cyc = 0;
	// Free-running core clock
	always #4 core_clk = ~core_clk;
	regulator_power_control #(.SETTLE_CYCLES(24'h8)) i_regulator_power_control (.core_clk(core_clk),
		.rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wake_pin_in(wake_pin_in), .wake_pin_out(), .wake_pin_oe(wake_pin_oe), .rtc_alarm(rtc_alarm),
		.core_regulator_strap(core_regulator_strap), .analog_regulator_on(ana_on), .core_regulator_on(core_on),
		.usb_regulator_on(usb_on), .core_regulator_low_voltage(low_v), .bandgap_on(bg_on),
		.analog_por_on(por_on), .rtc_clock_out_enable(clk_out), .supply_settling(settling));
	wake_source i_wake_source (.wake_pin_oe(wake_pin_oe), .ext_high(ext), .wake_pin_in(wake_pin_in));
	// Expected register images, reserved bits dropped
	function automatic logic [31:0] exp_pm(input logic [31:0] d);
		return {27'h0, d[4:0]};
	endfunction
	function automatic logic [31:0] exp_rc(input logic [31:0] d);
		return {30'h0, d[1:0]};
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Single AHB transfer; waits on ready rather than assuming zero wait
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		logic [31:0] d;
		d = $urandom(30760);
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		// Reset values and an unmapped word
		bus(0, 16'h1930, 0);
		chk("pm reset", rd, 32'h10);
		bus(0, 16'h7004, 0);
		chk("rc reset", rd, 32'h0);
		chk("low voltage", low_v, 0);
		bus(0, 16'h7ffc, 0);
		chk("unmapped", rd, 32'h0);
		// Random settings with reserved bits set, power-down bits kept clear
		repeat (8) begin
			d = $urandom;
			bus(1, 16'h7004, d);
			bus(0, 16'h7004, 0);
			chk("rc", rd, exp_rc(d));
			chk("low voltage", low_v, d[1]);
			chk("usb", usb_on, d[0]);
			d = d & 32'hfffffff9;
			bus(1, 16'h1930, d);
			bus(0, 16'h1930, 0);
			chk("pm", rd, exp_pm(d));
			chk("clock out", clk_out, d[0]);
			chk("wake oe", wake_pin_oe, d[3] & ~d[4]);
		end
		bus(1, 16'h7004, 32'h3);
		// Pin wake, alarm after bandgap down, pin ignored as output
		for (int i = 0; i < 3; i++) begin
			bus(1, 16'h1930, i == 2 ? 32'h1a : i == 1 ? 32'h14 : 32'h12);
			@(posedge core_clk);
			chk("bandgap", bg_on, i != 1);
			chk("usb down", usb_on, 0);
			chk("core down", core_on, 0);
			ext <= i != 1;
			repeat (6) @(posedge core_clk);
			chk("pin wake", ana_on, i == 0);
			rtc_alarm <= i != 0;
			do @(posedge core_clk); while (ana_on !== 1'b1);
			ext <= 1'b0;
			rtc_alarm <= 1'b0;
			do @(posedge core_clk); while (settling !== 1'b0);
			bus(0, 16'h1930, 0);
			chk("woken", rd, i == 2 ? 32'h18 : 32'h10);
			chk("usb back", usb_on, 1);
		end
		// Wake causes: pin first, then alarms; write one clears both
		bus(0, 16'h7008, 0);
		chk("wake causes", rd, 32'h18);
		bus(1, 16'h7008, 32'h18);
		bus(0, 16'h7008, 0);
		chk("causes cleared", rd, 32'h0);
		// Core regulator follows the board strap
		core_regulator_strap <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk("core strap high", core_on, 0);
		core_regulator_strap <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk("core strap low", core_on, 1);
		test_done();
	end
endmodule
